// ### tbi_inserter.v
/*
 * teletext bit inserter: asks an outside source for teletext bits, samples
 * them after a programmed delay, buffers them and adds them into the
 * composite and luma samples inside a per-line insertion window.
 * assumes hsync_lead, field_odd, line_number and the video samples come
 * from encoder logic on clk; teletext_data_in is an asynchronous pin.
 */
`timescale 1ns/100ps
`include "tbi_defines.vh"

// How it works
// - Inserted teletext begins 9.78 us after the leading hsync edge in PAL and 10.5 us in NTSC.
// - Received bits are smoothed and added into both the composite and the luma outputs.
// - Each bit is sampled the programmed delay after its request rose, and the source keeps to it.
// - The request train starts at the programmed horizontal position after hsync.
// - The window holds 360 bits at 6.9375 Mbit/s in the PAL format.
// - The window holds 296 bits at 5.7272 Mbit/s in the world-standard format.
// - The window holds 288 bits at 5.7272 Mbit/s in the NABTS format.
// - With the enable bit clear the window never opens and nothing is added.
// - In the odd field only lines from the odd first line to the odd last line are used.
// - In the even field only lines from the even first line to the even last line are used.
// - The two pins act as teletext pins only when the pin select bit chooses that use.
module tbi_inserter (
    input wire clk,
    input wire arst_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire hsync_lead,
    input wire field_odd,
    input wire [9:0] line_number,
    input wire [9:0] cvbs_in,
    input wire [9:0] luma_in,
    output reg [9:0] cvbs_out,
    output reg [9:0] luma_out,
    input wire teletext_data_in,
    output reg text_request_or_half_clock_pin
);
    // software settings
    reg teletext_insert_enable;
    reg pin_select;
    reg pal_mode;
    reg [1:0] text_format;
    reg [11:0] request_start_position;
    reg [7:0] request_to_data_delay;
    reg [9:0] odd_field_first_line;
    reg [9:0] odd_field_last_line;
    reg [9:0] even_field_first_line;
    reg [9:0] even_field_last_line;
    reg [9:0] insert_amplitude;
    reg underflow;
    localparam [5:0] ctrl_reset_value = `TBI_CTRL_RST;

    // line timing
    reg [11:0] hcount;
    reg line_active;
    reg [3:0] req_hold;
    reg half_clock;
    reg ttx_meta;
    reg ttx_sync;
    reg bit_now;
    reg bit_prev;
    reg [10:0] level;

    wire [63:0] step_pal_w;
    wire [63:0] step_525_w;
    wire [23:0] step;
    wire [8:0] nbits;
    wire [31:0] win_start;
    wire [12:0] sample_start;
    wire line_in_range;
    wire req_tick;
    wire req_busy;
    wire smp_tick;
    wire smp_busy;
    wire drv_tick;
    wire drv_busy;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_data;
    wire [4:0] fifo_level;
    wire train_hold;
    wire req_level;
    wire next_pin;
    wire next_underflow;
    wire [10:0] next_level;
    wire ufl_clear;

    function [9:0] sat_add;
        input [9:0] a;
        input [10:0] b;
        reg [11:0] sum;
        begin
            sum = {2'b00, a} + {1'b0, b};
            sat_add = (sum > 12'h3FF) ? 10'h3FF : sum[9:0];
        end
    endfunction

    function in_span;
        input [9:0] line;
        input [9:0] first;
        input [9:0] last;
        begin
            in_span = (line >= first) && (line <= last);
        end
    endfunction

    // true once per active line, in the cycle the horizontal counter stands at pos
    function hc_hit;
        input [12:0] pos;
        begin
            hc_hit = line_active && !hsync_lead && (hcount != 12'hFFF)
                && ({1'b0, hcount} == pos);
        end
    endfunction

    assign step_pal_w = `TBI_NCO_STEP(`TBI_RATE_PAL_HZ);
    assign step_525_w = `TBI_NCO_STEP(`TBI_RATE_525_HZ);
    assign step = (text_format == `TBI_FMT_PAL) ? step_pal_w[23:0]
        : step_525_w[23:0];
    assign nbits = (text_format == `TBI_FMT_PAL) ? `TBI_BITS_PAL
        : (text_format == `TBI_FMT_WORLD) ? `TBI_BITS_WORLD
        : `TBI_BITS_NABTS;
    assign win_start = pal_mode ? `TBI_POS_PAL_CYC : `TBI_POS_NTSC_CYC;
    assign sample_start = {1'b0, request_start_position}
        + {5'h00, request_to_data_delay};

    assign line_in_range = field_odd
        ? in_span(line_number, odd_field_first_line, odd_field_last_line)
        : in_span(line_number, even_field_first_line, even_field_last_line);

    // request and sample trains freeze together so their spacing stays exact
    assign train_hold = !fifo_in_ready;

    tbi_bit_train u_req_train (
        .clk(clk),
        .arst_n(arst_n),
        .start(hc_hit({1'b0, request_start_position})),
        .hold(train_hold),
        .step(step),
        .nbits(nbits),
        .tick(req_tick),
        .busy(req_busy)
    );

    tbi_bit_train u_smp_train (
        .clk(clk),
        .arst_n(arst_n),
        .start(hc_hit(sample_start)),
        .hold(train_hold),
        .step(step),
        .nbits(nbits),
        .tick(smp_tick),
        .busy(smp_busy)
    );

    tbi_bit_train u_drv_train (
        .clk(clk),
        .arst_n(arst_n),
        .start(hc_hit(win_start[12:0])),
        .hold(1'b0),
        .step(step),
        .nbits(nbits),
        .tick(drv_tick),
        .busy(drv_busy)
    );

    // sampled bits wait here until the window opens; flushed every line
    tbi_fifo #(
        .W(1),
        .D(16),
        .AW(4)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .flush(hsync_lead),
        .in_valid(smp_tick && line_active),
        .in_ready(fifo_in_ready),
        .in_data(ttx_sync),
        .out_valid(fifo_out_valid),
        .out_ready(drv_tick),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    assign req_level = line_active && (req_hold != 4'h0);
    assign next_pin = pin_select ? req_level : !half_clock;
    assign ufl_clear = reg_wr && (reg_addr == `TBI_REG_STATUS)
        && reg_wdata[`TBI_STAT_UFL_BIT];
    // a new underflow in the clearing cycle wins
    assign next_underflow = (drv_tick && !fifo_out_valid) || (underflow && !ufl_clear);
    assign next_level = drv_busy
        ? ({1'b0, bit_now ? insert_amplitude : 10'h000}
            + {1'b0, bit_prev ? insert_amplitude : 10'h000}) >> 1
        : 11'h000;

    // pin synchroniser; the first stage feeds only the second
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ttx_meta <= 1'b0;
            ttx_sync <= 1'b0;
        end else begin
            ttx_meta <= teletext_data_in;
            ttx_sync <= ttx_meta;
        end
    end

    // horizontal counter and per-line gate, decided at the hsync edge
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hcount <= 12'hFFF;
            line_active <= 1'b0;
        end else if (hsync_lead) begin
            hcount <= 12'h000;
            line_active <= teletext_insert_enable && pin_select
                && line_in_range;
        end else if (hcount != 12'hFFF) begin
            hcount <= hcount + 1'b1;
        end
    end

    // request pulse: a fixed high time per bit, well under a bit period
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_hold <= 4'h0;
            half_clock <= 1'b0;
            text_request_or_half_clock_pin <= 1'b0;
        end else begin
            if (req_tick) begin
                req_hold <= `TBI_REQ_HIGH_CYC;
            end else if (req_hold != 4'h0) begin
                req_hold <= req_hold - 1'b1;
            end
            half_clock <= !half_clock;
            text_request_or_half_clock_pin <= next_pin;
        end
    end

    // two-tap smoothing of the bit stream, then added into both outputs
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_now <= 1'b0;
            bit_prev <= 1'b0;
            level <= 11'h000;
            cvbs_out <= 10'h000;
            luma_out <= 10'h000;
            underflow <= 1'b0;
        end else begin
            if (!drv_busy) begin
                bit_now <= 1'b0;
                bit_prev <= 1'b0;
            end else if (drv_tick) begin
                bit_prev <= bit_now;
                bit_now <= fifo_out_valid && fifo_out_data;
            end
            level <= next_level;
            cvbs_out <= sat_add(cvbs_in, level);
            luma_out <= sat_add(luma_in, level);
            underflow <= next_underflow;
        end
    end

    // register writes
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            teletext_insert_enable <= ctrl_reset_value[`TBI_CTRL_EN_BIT];
            pin_select <= ctrl_reset_value[`TBI_CTRL_PINSEL_BIT];
            pal_mode <= ctrl_reset_value[`TBI_CTRL_PAL_BIT];
            text_format <= ctrl_reset_value[`TBI_CTRL_FMT_MSB:`TBI_CTRL_FMT_LSB];
            request_start_position <= `TBI_START_RST;
            request_to_data_delay <= `TBI_DELAY_RST;
            odd_field_first_line <= `TBI_ODD_FIRST_RST;
            odd_field_last_line <= `TBI_ODD_LAST_RST;
            even_field_first_line <= `TBI_EVEN_FIRST_RST;
            even_field_last_line <= `TBI_EVEN_LAST_RST;
            insert_amplitude <= `TBI_AMPL_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `TBI_REG_CTRL: begin
                    teletext_insert_enable <= reg_wdata[`TBI_CTRL_EN_BIT];
                    pin_select <= reg_wdata[`TBI_CTRL_PINSEL_BIT];
                    pal_mode <= reg_wdata[`TBI_CTRL_PAL_BIT];
                    text_format <= reg_wdata[`TBI_CTRL_FMT_MSB:`TBI_CTRL_FMT_LSB];
                end
                `TBI_REG_TIMING: begin
                    request_start_position <= reg_wdata[`TBI_START_MSB:`TBI_START_LSB];
                    request_to_data_delay <= reg_wdata[`TBI_DELAY_MSB:`TBI_DELAY_LSB];
                end
                `TBI_REG_ODD: begin
                    odd_field_first_line <= reg_wdata[`TBI_FIRST_MSB:`TBI_FIRST_LSB];
                    odd_field_last_line <= reg_wdata[`TBI_LAST_MSB:`TBI_LAST_LSB];
                end
                `TBI_REG_EVEN: begin
                    even_field_first_line <= reg_wdata[`TBI_FIRST_MSB:`TBI_FIRST_LSB];
                    even_field_last_line <= reg_wdata[`TBI_LAST_MSB:`TBI_LAST_LSB];
                end
                `TBI_REG_AMPL: begin
                    insert_amplitude <= reg_wdata[9:0];
                end
                default: begin
                end
            endcase
        end
    end

    // register reads: data stand for the one cycle after the strobe
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `TBI_REG_CTRL:
                    reg_rdata <= {26'h000_0000, text_format, 1'b0, pal_mode,
                        pin_select, teletext_insert_enable};
                `TBI_REG_TIMING:
                    reg_rdata <= {8'h00, request_to_data_delay, 4'h0,
                        request_start_position};
                `TBI_REG_ODD:
                    reg_rdata <= {6'h00, odd_field_last_line, 6'h00,
                        odd_field_first_line};
                `TBI_REG_EVEN:
                    reg_rdata <= {6'h00, even_field_last_line, 6'h00,
                        even_field_first_line};
                `TBI_REG_AMPL:
                    reg_rdata <= {22'h00_0000, insert_amplitude};
                `TBI_REG_STATUS:
                    reg_rdata <= {23'h00_0000, fifo_level, 1'b0, req_busy,
                        underflow, drv_busy};
                default:
                    reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // tbi_inserter

// ### tbi_defines.vh
/*
 * register map, field positions, reset values and timing counts of the
 * teletext bit inserter; assumes a 200 MHz core clock and byte addresses
 */
`ifndef TBI_DEFINES_VH
`define TBI_DEFINES_VH

// register byte offsets
`define TBI_REG_CTRL 8'h00
`define TBI_REG_TIMING 8'h04
`define TBI_REG_ODD 8'h08
`define TBI_REG_EVEN 8'h0C
`define TBI_REG_AMPL 8'h10
`define TBI_REG_STATUS 8'h14

// control fields
`define TBI_CTRL_EN_BIT 0
`define TBI_CTRL_PINSEL_BIT 1
`define TBI_CTRL_PAL_BIT 2
`define TBI_CTRL_FMT_LSB 4
`define TBI_CTRL_FMT_MSB 5
`define TBI_FMT_PAL 2'h0
`define TBI_FMT_WORLD 2'h1
`define TBI_FMT_NABTS 2'h2

// timing and line range fields
`define TBI_START_LSB 0
`define TBI_START_MSB 11
`define TBI_DELAY_LSB 16
`define TBI_DELAY_MSB 23
`define TBI_FIRST_LSB 0
`define TBI_FIRST_MSB 9
`define TBI_LAST_LSB 16
`define TBI_LAST_MSB 25

// status fields
`define TBI_STAT_WIN_BIT 0
`define TBI_STAT_UFL_BIT 1
`define TBI_STAT_REQ_BIT 2
`define TBI_STAT_LVL_LSB 4

// reset values
`define TBI_CTRL_RST 6'h04
`define TBI_START_RST 12'h0_100
`define TBI_DELAY_RST 8'h10
`define TBI_ODD_FIRST_RST 10'h007
`define TBI_ODD_LAST_RST 10'h016
`define TBI_EVEN_FIRST_RST 10'h140
`define TBI_EVEN_LAST_RST 10'h14F
`define TBI_AMPL_RST 10'h0C8

// bits per insertion window
`define TBI_BITS_PAL 9'd360
`define TBI_BITS_WORLD 9'd296
`define TBI_BITS_NABTS 9'd288

// timing: clock, insertion position in ns, bit rates in bit/s
`define TBI_CLK_MHZ 200
`define TBI_CLK_HZ 64'd200000000
`define TBI_POS_PAL_NS 9780
`define TBI_POS_NTSC_NS 10500
`define TBI_POS_PAL_CYC ((`TBI_POS_PAL_NS * `TBI_CLK_MHZ) / 1000)
`define TBI_POS_NTSC_CYC ((`TBI_POS_NTSC_NS * `TBI_CLK_MHZ) / 1000)
`define TBI_RATE_PAL_HZ 64'd6937500
`define TBI_RATE_525_HZ 64'd5727200
`define TBI_NCO_STEP(r) (((r) * 64'd16777216) / `TBI_CLK_HZ)
`define TBI_REQ_HIGH_CYC 4'd8

`endif

// ### tbi_fifo.v
/*
 * synchronous fifo with valid/ready on both sides and a flush;
 * assumes one clock and that flush is a one-cycle pulse
 */
`timescale 1ns/100ps
module tbi_fifo #(
    parameter W = 1,
    parameter D = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire arst_n,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data,
    output wire [AW:0] level
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != D);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign level = count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // tbi_fifo

// ### tbi_bit_train.v
/*
 * fractional bit-rate generator: after start, gives nbits one-cycle ticks
 * spaced at step/2^24 of the clock rate; assumes hold freezes the phase
 */
`timescale 1ns/100ps
module tbi_bit_train (
    input wire clk,
    input wire arst_n,
    input wire start,
    input wire hold,
    input wire [23:0] step,
    input wire [8:0] nbits,
    output reg tick,
    output reg busy
);
    reg [23:0] acc;
    reg [8:0] left;
    wire [24:0] next_acc;

    assign next_acc = {1'b0, acc} + {1'b0, step};

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc <= 24'h00_0000;
            left <= 9'h000;
            tick <= 1'b0;
            busy <= 1'b0;
        end else if (start) begin
            // first tick two cycles after start, so bit one lands on its position
            acc <= 24'hFF_FFFF;
            left <= nbits;
            tick <= 1'b0;
            busy <= (nbits != 9'h000);
        end else if (busy && !hold) begin
            acc <= next_acc[23:0];
            tick <= next_acc[24];
            if (next_acc[24]) begin
                left <= left - 1'b1;
                if (left == 9'h001) begin
                    busy <= 1'b0;
                end
            end
        end else begin
            tick <= 1'b0;
        end
    end
endmodule // tbi_bit_train

// ### tbi_inserter_asserts.sv
/*
 * concurrent checks on the ports of tbi_inserter, bound into every instance.
 * assumes the control, timing and level registers change only between lines.
 */
`timescale 1ns/100ps
`include "tbi_defines.vh"
module tbi_inserter_asserts (
    input wire clk,
    input wire arst_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire hsync_lead,
    input wire field_odd,
    input wire [9:0] line_number,
    input wire [9:0] cvbs_in,
    input wire [9:0] luma_in,
    input wire [9:0] cvbs_out,
    input wire [9:0] luma_out,
    input wire teletext_data_in,
    input wire text_request_or_half_clock_pin
);
    wire pin = text_request_or_half_clock_pin;
    logic sel;
    logic en;
    logic pal;
    logic [11:0] start;
    logic [9:0] ampl;
    logic [2:0] cyc;
    logic [13:0] hcnt;
    wire [13:0] pos = pal ? 14'(`TBI_POS_PAL_CYC) : 14'(`TBI_POS_NTSC_CYC);
    // mirrors of the control fields, so checks follow the programmed mode
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel <= 1'b0;
            en <= 1'b0;
            pal <= 1'b1;
            start <= `TBI_START_RST;
            ampl <= `TBI_AMPL_RST;
            cyc <= 3'h0;
            hcnt <= 14'h3fff;
        end else begin
            if (cyc != 3'h7)
                cyc <= cyc + 3'h1;
            if (hsync_lead)
                hcnt <= 14'h0000;
            else if (hcnt != 14'h3fff)
                hcnt <= hcnt + 14'h0001;
            if (reg_wr && reg_addr == `TBI_REG_CTRL) begin
                en <= reg_wdata[`TBI_CTRL_EN_BIT];
                sel <= reg_wdata[`TBI_CTRL_PINSEL_BIT];
                pal <= reg_wdata[`TBI_CTRL_PAL_BIT];
            end
            if (reg_wr && reg_addr == `TBI_REG_TIMING)
                start <= reg_wdata[11:0];
            if (reg_wr && reg_addr == `TBI_REG_AMPL)
                ampl <= reg_wdata[9:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_req_rise;
        sel && $past(sel, 2) && $rose(pin);
    endsequence
    sequence s_req_burst;
        pin [*8] ##1 !pin;
    endsequence
    sequence s_video_clean;
        cvbs_out == $past(cvbs_in) && luma_out == $past(luma_in);
    endsequence
    a_req_high_eight: assert property (s_req_rise |-> s_req_burst)
        else $error("request pulse width wrong");
    a_req_needs_enable: assert property (s_req_rise |-> en && $past(en, 2))
        else $error("request while disabled");
    a_req_after_start: assert property (s_req_rise |-> hcnt > {2'b00, start})
        else $error("request before start position");
    a_half_clock_run: assert property (cyc == 3'h7 && !sel && !$past(sel) && !$past(sel, 2)
        |-> $changed(pin))
        else $error("half clock stalled");
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    a_pass_disabled: assert property (cyc == 3'h7 && !en && !$past(en) && !$past(en, 2)
        |-> s_video_clean)
        else $error("video altered while disabled");
    a_quiet_early: assert property (cyc == 3'h7 && hcnt <= pos |-> s_video_clean)
        else $error("insertion before position");
    a_same_offset: assert property (cyc == 3'h7 && ampl < 10'h200 && $past(cvbs_in) < 10'h200
        && $past(luma_in) < 10'h200
        |-> cvbs_out - $past(cvbs_in) == luma_out - $past(luma_in))
        else $error("luma and composite levels differ");
endmodule // tbi_inserter_asserts

bind tbi_inserter tbi_inserter_asserts u_chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hsync_lead(hsync_lead), .field_odd(field_odd), .line_number(line_number),
    .cvbs_in(cvbs_in), .luma_in(luma_in), .cvbs_out(cvbs_out), .luma_out(luma_out),
    .teletext_data_in(teletext_data_in),
    .text_request_or_half_clock_pin(text_request_or_half_clock_pin));

// ### tbi_text_source.sv
/*
 * teletext source model: answers each request rise with a one bit that is
 * valid only around the programmed sample point; assumes delay below 58.
 */
`timescale 1ns/100ps
module tbi_text_source (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic request,
    input wire logic [7:0] delay,
    output logic data,
    output logic [15:0] req_count
);
    logic last;
    logic [63:0] hist;
    always @(posedge clk or negedge arst_n) begin : drive
        integer k;
        logic hit;
        hit = 1'b0;
        if (!arst_n) begin
            last <= 1'b0;
            hist <= 64'h0;
            data <= 1'b0;
            req_count <= 16'h0000;
        end else begin
            for (k = 0; k < 64; k = k + 1)
                if (hist[k] && k + 6 >= delay && k <= delay)
                    hit = 1'b1;
            last <= request;
            hist <= {hist[62:0], request && !last};
            if (request && !last)
                req_count <= req_count + 16'h0001;
            // zero between bits, so a mistimed sample reads a wrong bit
            data <= hit;
        end
    end
endmodule // tbi_text_source

// ### tbi_inserter_tb.sv
/*
 * self-checking bench of tbi_inserter with the source model on its pins;
 * assumes the checker is bound in and constant video input levels.
 */
`timescale 1ns/100ps
`include "tbi_defines.vh"
module tbi_inserter_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic hsync_lead = 1'b0;
    logic field_odd = 1'b1;
    logic [9:0] line_number = 10'h000;
    logic [9:0] cvbs_in = 10'h100;
    logic [9:0] luma_in = 10'h080;
    logic [9:0] cvbs_out;
    logic [9:0] luma_out;
    logic ttx_pin;
    logic req_pin;
    logic [7:0] src_delay = `TBI_DELAY_RST;
    logic [15:0] req_count;
    logic [31:0] rv;
    integer error_cnt = 0;
    integer samples_checked = 0;
    always #2.5 clk = ~clk;
    tbi_inserter dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync_lead(hsync_lead),
        .field_odd(field_odd), .line_number(line_number), .cvbs_in(cvbs_in),
        .luma_in(luma_in), .cvbs_out(cvbs_out), .luma_out(luma_out),
        .teletext_data_in(ttx_pin), .text_request_or_half_clock_pin(req_pin));
    tbi_text_source src (.clk(clk), .arst_n(arst_n), .request(req_pin), .delay(src_delay),
        .data(ttx_pin), .req_count(req_count));
    task automatic wrap_up;
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    // nreq ffff: pin in its clock role, request count not meaningful
    task automatic run_line(input logic odd, input logic [9:0] ln, input logic [15:0] nreq,
                            input integer pos, input integer span);
        integer k;
        integer first;
        logic [15:0] c0;
        first = 0;
        @(posedge clk);
        hsync_lead <= 1'b1;
        field_odd <= odd;
        line_number <= ln;
        @(posedge clk);
        hsync_lead <= 1'b0;
        // taken late so toggles of a just-left clock mode are not counted
        c0 = req_count;
        for (k = 1; k <= span; k = k + 1) begin
            // look between edges, where registered outputs have settled
            @(negedge clk);
            if (first == 0 && (cvbs_out !== cvbs_in || luma_out !== luma_in))
                first = k;
            if (k == 5000 && nreq != 16'h0000) begin
                check({22'h0, cvbs_out}, {22'h0, cvbs_in + `TBI_AMPL_RST});
                check({22'h0, luma_out}, {22'h0, luma_in + `TBI_AMPL_RST});
            end
        end
        if (nreq != 16'hffff)
            check({16'h0, req_count - c0}, {16'h0, nreq});
        if (nreq == 16'h0000 || nreq == 16'hffff)
            check(first, 0);
        else
            check({31'h0, first >= pos && first <= pos + 8}, 1);
        rd(`TBI_REG_STATUS, rv);
        check(rv & 32'h0000_0002, 32'h0000_0000);
    endtask
    task automatic run_fmt(input logic [31:0] ctrl, input logic [7:0] dly, input logic odd,
                           input logic [9:0] ln, input logic [15:0] nreq, input integer pos);
        wr(`TBI_REG_CTRL, ctrl);
        src_delay <= dly;
        wr(`TBI_REG_TIMING, {8'h0, dly, 4'h0, `TBI_START_RST});
        run_line(odd, ln, nreq, pos, 12600);
    endtask
    initial begin
        #500000;
        error_cnt = error_cnt + 1;
        wrap_up;
    end
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rv[0] = req_pin;
        @(negedge clk);
        check({31'h0, req_pin}, {31'h0, ~rv[0]});
        rd(`TBI_REG_CTRL, rv);
        check(rv, {26'h0, `TBI_CTRL_RST});
        rd(`TBI_REG_TIMING, rv);
        check(rv, {8'h0, `TBI_DELAY_RST, 4'h0, `TBI_START_RST});
        rd(`TBI_REG_ODD, rv);
        check(rv, {6'h0, `TBI_ODD_LAST_RST, 6'h0, `TBI_ODD_FIRST_RST});
        rd(`TBI_REG_EVEN, rv);
        check(rv, {6'h0, `TBI_EVEN_LAST_RST, 6'h0, `TBI_EVEN_FIRST_RST});
        rd(`TBI_REG_AMPL, rv);
        check(rv, {22'h0, `TBI_AMPL_RST});
        wr(8'h18, 32'hffff_ffff);
        rd(8'h18, rv);
        check(rv, 32'h0000_0000);
        wr(`TBI_REG_CTRL, 32'h0000_0006);
        run_line(1'b1, 10'h00a, 16'h0000, 0, 3000);
        wr(`TBI_REG_CTRL, 32'h0000_0005);
        run_line(1'b1, 10'h00a, 16'hffff, 0, 3000);
        run_fmt(32'h0000_0007, 8'h10, 1'b1, 10'h007, 16'h0168, `TBI_POS_PAL_CYC);
        run_fmt(32'h0000_0013, 8'h20, 1'b1, 10'h016, 16'h0128, `TBI_POS_NTSC_CYC);
        run_fmt(32'h0000_0023, 8'h10, 1'b0, 10'h140, 16'h0120, `TBI_POS_NTSC_CYC);
        run_fmt(32'h0000_0037, 8'h10, 1'b0, 10'h14f, 16'h0120, `TBI_POS_PAL_CYC);
        run_line(1'b1, 10'h006, 16'h0000, 0, 3000);
        run_line(1'b1, 10'h017, 16'h0000, 0, 3000);
        run_line(1'b0, 10'h13f, 16'h0000, 0, 3000);
        run_line(1'b0, 10'h150, 16'h0000, 0, 3000);
        run_line(1'b1, 10'h140, 16'h0000, 0, 3000);
        wrap_up;
    end
endmodule // tbi_inserter_tb
